// ---- shared/msch_regs.svh ----
// register offsets, field positions, interrupt bits and reset values of the command handler
`ifndef MSCH_REGS_SVH
`define MSCH_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define MSCH_CMD_OFF 12'h000
`define MSCH_STATE_OFF 12'h004
`define MSCH_AVAIL_OFF 12'h008
`define MSCH_IRQ_STAT_OFF 12'h00C
`define MSCH_IRQ_MASK_OFF 12'h010
`define MSCH_ERR_OFF 12'h014

// ----------------------------------------
// command word fields
// ----------------------------------------
`define MSCH_OP_MSB 3
`define MSCH_OP_LSB 0
`define MSCH_ARG_MSB 7
`define MSCH_ARG_LSB 4
`define MSCH_SEL_MSB 9
`define MSCH_SEL_LSB 8
`define MSCH_SELEN_BIT 12

// ----------------------------------------
// state word fields
// ----------------------------------------
`define MSCH_ST_LOG_BIT 0
`define MSCH_ST_CAUSE_MSB 6
`define MSCH_ST_CAUSE_LSB 4
`define MSCH_ST_TREND_BIT 8
`define MSCH_ST_FREEZE_BIT 9
`define MSCH_ST_SURGE_MSB 14
`define MSCH_ST_SURGE_LSB 12

// ----------------------------------------
// interrupt bits and reset values
// ----------------------------------------
`define MSCH_IRQ_CMD_ERR 0
`define MSCH_IRQ_LOG_END 1
`define MSCH_IRQ_SURGE_OK 2
`define MSCH_AVAIL_RST 3'h1
`define MSCH_MASK_RST 3'h0

`endif

// ---- shared/msch_pkg.sv ----
// types of the command handler
package msch_pkg;
    typedef enum logic [3:0] {
        MSCH_OP_NONE = 4'h0,
        MSCH_OP_CLR_SURGE = 4'h1,
        MSCH_OP_LOG = 4'h2,
        MSCH_OP_TREND = 4'h3,
        MSCH_OP_FREEZE = 4'h4
    } msch_op_t;

    typedef enum logic [2:0] {
        MSCH_CAUSE_NONE = 3'h0,
        MSCH_CAUSE_SIZE = 3'h1,
        MSCH_CAUSE_FULL = 3'h2,
        MSCH_CAUSE_WRERR = 3'h3,
        MSCH_CAUSE_REMOVED = 3'h4
    } msch_cause_t;

    typedef enum logic [1:0] {
        MSCH_ERR_NONE = 2'h0,
        MSCH_ERR_OPCODE = 2'h1,
        MSCH_ERR_ARG = 2'h2,
        MSCH_ERR_ANALYZER = 2'h3
    } msch_err_t;

    typedef enum logic [1:0] {
        MSCH_LOG_IDLE = 2'b01,
        MSCH_LOG_RUN = 2'b10
    } msch_log_st_t;
endpackage

// ---- shared/msch_if.sv ----
// register access path between the bus slave and the command handler
`timescale 1ns/1ps
interface msch_if;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic hit;
    modport bus (output wr, output addr, output wdata, input rdata, input hit);
    modport regs (input wr, input addr, input wdata, output rdata, output hit);
endinterface

// ---- src/msch_apb.sv ----
// apb slave front end of the command handler
`timescale 1ns/1ps
module msch_apb (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // register side
    msch_if.bus rb
);
    // zero wait states: read data is caught in the setup cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~rb.hit;
    assign rb.addr = paddr;
    assign rb.wdata = pwdata;
    assign rb.wr = psel & penable & pwrite & rb.hit;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= rb.hit ? rb.rdata : 32'h0000_0000;
        end
    end
endmodule

// ---- src/msch_irq.sv ----
// sticky interrupt status with mask and one level output
`timescale 1ns/1ps
`include "msch_regs.svh"
module msch_irq #(
    parameter int N = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // events and software access
    input wire logic [N-1:0] set,
    input wire logic stat_wr,
    input wire logic mask_wr,
    input wire logic [N-1:0] wdata,
    // state
    output logic [N-1:0] status,
    output logic [N-1:0] mask,
    output logic irq
);
    // set wins over a write-one-to-clear in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            status <= '0;
        end else begin
            status <= (status & ~(stat_wr ? wdata : '0)) | set;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            mask <= N'(`MSCH_MASK_RST);
        end else if (mask_wr) begin
            mask <= wdata;
        end
    end

    assign irq = |(status & mask);
endmodule

// ---- src/msch_top.sv ----
// measurement state command handler: command decode, state and register map
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "msch_regs.svh"
module msch_top #(
    parameter int NUM_ANALYZERS = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // measurement engine
    input wire logic period_done,
    output logic [NUM_ANALYZERS-1:0] surge_clear,
    output logic [NUM_ANALYZERS-1:0] surge_valid,
    output logic freeze,
    // logging storage
    input wire logic log_fault,
    input wire logic [2:0] log_fault_cause,
    output logic log_run,
    // trend capture
    output logic trend_run,
    output logic trend_discard,
    // interrupt
    output logic irq
);
    // ----------------------------------------
    // bus slave and register access
    // ----------------------------------------
    msch_if rb ();

    msch_apb u_apb (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rb(rb)
    );

    function automatic logic addr_hit(input logic [11:0] a);
        case (a)
            `MSCH_CMD_OFF, `MSCH_STATE_OFF, `MSCH_AVAIL_OFF,
            `MSCH_IRQ_STAT_OFF, `MSCH_IRQ_MASK_OFF, `MSCH_ERR_OFF: addr_hit = 1'b1;
            default: addr_hit = 1'b0;
        endcase
    endfunction

    // binary control arguments take only 0 or 1
    function automatic logic arg_ok(input msch_pkg::msch_op_t op, input logic [3:0] a);
        case (op)
            msch_pkg::MSCH_OP_CLR_SURGE: arg_ok = (a == 4'h0);
            msch_pkg::MSCH_OP_LOG, msch_pkg::MSCH_OP_TREND,
            msch_pkg::MSCH_OP_FREEZE: arg_ok = (a <= 4'h1);
            default: arg_ok = 1'b0;
        endcase
    endfunction

    assign rb.hit = addr_hit(rb.addr);

    logic cmd_wr;
    logic stat_wr;
    logic mask_wr;
    logic avail_wr;
    assign cmd_wr = rb.wr && (rb.addr == `MSCH_CMD_OFF);
    assign stat_wr = rb.wr && (rb.addr == `MSCH_IRQ_STAT_OFF);
    assign mask_wr = rb.wr && (rb.addr == `MSCH_IRQ_MASK_OFF);
    assign avail_wr = rb.wr && (rb.addr == `MSCH_AVAIL_OFF);

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    msch_pkg::msch_op_t op;
    logic [3:0] arg;
    logic [1:0] sel;
    logic sel_en;
    logic [NUM_ANALYZERS-1:0] avail;
    logic sel_bad;
    logic sel_range_bad;
    logic op_known;
    msch_pkg::msch_err_t next_err;
    logic cmd_ok;

    assign op = msch_pkg::msch_op_t'(rb.wdata[`MSCH_OP_MSB:`MSCH_OP_LSB]);
    assign arg = rb.wdata[`MSCH_ARG_MSB:`MSCH_ARG_LSB];
    assign sel = rb.wdata[`MSCH_SEL_MSB:`MSCH_SEL_LSB];
    assign sel_en = rb.wdata[`MSCH_SELEN_BIT];
    assign sel_range_bad = (32'(sel) >= NUM_ANALYZERS);
    assign sel_bad = sel_en && (sel_range_bad || !avail[sel]);
    assign op_known = (op == msch_pkg::MSCH_OP_CLR_SURGE) || (op == msch_pkg::MSCH_OP_LOG)
        || (op == msch_pkg::MSCH_OP_TREND) || (op == msch_pkg::MSCH_OP_FREEZE);

    // analyzer check first, then opcode, then argument
    always_comb begin
        next_err = msch_pkg::MSCH_ERR_NONE;
        if (sel_bad) begin
            next_err = msch_pkg::MSCH_ERR_ANALYZER;
        end else if (!op_known) begin
            next_err = msch_pkg::MSCH_ERR_OPCODE;
        end else if (!arg_ok(op, arg)) begin
            next_err = msch_pkg::MSCH_ERR_ARG;
        end
    end

    assign cmd_ok = cmd_wr && (next_err == msch_pkg::MSCH_ERR_NONE);

    logic do_clr;
    logic do_log;
    logic do_trend;
    logic do_freeze;
    assign do_clr = cmd_ok && (op == msch_pkg::MSCH_OP_CLR_SURGE);
    assign do_log = cmd_ok && (op == msch_pkg::MSCH_OP_LOG);
    assign do_trend = cmd_ok && (op == msch_pkg::MSCH_OP_TREND);
    assign do_freeze = cmd_ok && (op == msch_pkg::MSCH_OP_FREEZE);

    msch_pkg::msch_err_t err;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            err <= msch_pkg::MSCH_ERR_NONE;
        end else if (cmd_wr) begin
            err <= next_err;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            avail <= NUM_ANALYZERS'(`MSCH_AVAIL_RST);
        end else if (avail_wr) begin
            avail <= rb.wdata[NUM_ANALYZERS-1:0];
        end
    end

    // ----------------------------------------
    // surge peak results
    // ----------------------------------------
    // with no selector every analyzer is cleared; a selector clears only that one
    logic [NUM_ANALYZERS-1:0] clr_set;
    always_comb begin
        clr_set = '0;
        if (do_clr) begin
            clr_set = sel_en ? NUM_ANALYZERS'(1) << sel : '1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            surge_clear <= '0;
        end else begin
            surge_clear <= clr_set;
        end
    end

    // a period that completes in the clear cycle does not count: the next one must
    logic [NUM_ANALYZERS-1:0] surge_ok_evt;
    assign surge_ok_evt = period_done ? ~surge_valid & ~clr_set : '0;

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            surge_valid <= '0;
        end else begin
            surge_valid <= (surge_valid | surge_ok_evt) & ~clr_set;
        end
    end

    // ----------------------------------------
    // logging
    // ----------------------------------------
    msch_pkg::msch_log_st_t log_st;
    msch_pkg::msch_cause_t cause;
    logic log_end_evt;

    // a storage fault only ends a run; a start in the same cycle wins
    assign log_end_evt = (log_st == msch_pkg::MSCH_LOG_RUN) && log_fault
        && !(do_log && arg[0]);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            log_st <= msch_pkg::MSCH_LOG_IDLE;
        end else begin
            case (log_st)
                msch_pkg::MSCH_LOG_IDLE: begin
                    if (do_log && arg[0]) begin
                        log_st <= msch_pkg::MSCH_LOG_RUN;
                    end
                end
                msch_pkg::MSCH_LOG_RUN: begin
                    if (do_log && !arg[0]) begin
                        log_st <= msch_pkg::MSCH_LOG_IDLE;
                    end else if (log_end_evt) begin
                        log_st <= msch_pkg::MSCH_LOG_IDLE;
                    end
                end
                default: log_st <= msch_pkg::MSCH_LOG_IDLE;
            endcase
        end
    end

    assign log_run = (log_st == msch_pkg::MSCH_LOG_RUN);

    // an unknown fault code is kept as a write error rather than lost
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cause <= msch_pkg::MSCH_CAUSE_NONE;
        end else if (do_log && arg[0]) begin
            cause <= msch_pkg::MSCH_CAUSE_NONE;
        end else if (log_end_evt) begin
            case (log_fault_cause)
                3'h1: cause <= msch_pkg::MSCH_CAUSE_SIZE;
                3'h2: cause <= msch_pkg::MSCH_CAUSE_FULL;
                3'h4: cause <= msch_pkg::MSCH_CAUSE_REMOVED;
                default: cause <= msch_pkg::MSCH_CAUSE_WRERR;
            endcase
        end
    end

    // ----------------------------------------
    // trend capture and freeze
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            trend_run <= 1'b0;
            trend_discard <= 1'b0;
        end else begin
            trend_discard <= do_trend && arg[0];
            if (do_trend) begin
                trend_run <= arg[0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            freeze <= 1'b0;
        end else if (do_freeze) begin
            freeze <= arg[0];
        end
    end

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    logic [2:0] irq_set;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    assign irq_set[`MSCH_IRQ_CMD_ERR] = cmd_wr && (next_err != msch_pkg::MSCH_ERR_NONE);
    assign irq_set[`MSCH_IRQ_LOG_END] = log_end_evt;
    assign irq_set[`MSCH_IRQ_SURGE_OK] = |surge_ok_evt;

    msch_irq #(
        .N(3)
    ) u_irq (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .set(irq_set),
        .stat_wr(stat_wr),
        .mask_wr(mask_wr),
        .wdata(rb.wdata[2:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    logic [31:0] state_word;
    always_comb begin
        state_word = 32'h0000_0000;
        state_word[`MSCH_ST_LOG_BIT] = log_run;
        state_word[`MSCH_ST_CAUSE_MSB:`MSCH_ST_CAUSE_LSB] = cause;
        state_word[`MSCH_ST_TREND_BIT] = trend_run;
        state_word[`MSCH_ST_FREEZE_BIT] = freeze;
        state_word[`MSCH_ST_SURGE_MSB:`MSCH_ST_SURGE_LSB] = 3'(surge_valid);
    end

    always_comb begin
        case (rb.addr)
            `MSCH_STATE_OFF: rb.rdata = state_word;
            `MSCH_AVAIL_OFF: rb.rdata = 32'(avail);
            `MSCH_IRQ_STAT_OFF: rb.rdata = {29'h0000_0000, irq_status};
            `MSCH_IRQ_MASK_OFF: rb.rdata = {29'h0000_0000, irq_mask};
            `MSCH_ERR_OFF: rb.rdata = {30'h0000_0000, err};
            default: rb.rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_sel_unavail_err: assert property (
        cmd_wr && sel_en && !sel_range_bad && !avail[sel] |=> err == msch_pkg::MSCH_ERR_ANALYZER
            && irq_status[`MSCH_IRQ_CMD_ERR])
        else $error("unavailable analyzer not flagged");

    a_clear_all_surge: assert property (
        do_clr && !sel_en |=> surge_clear == '1 && surge_valid == '0)
        else $error("surge clear did not erase all results");

    a_surge_wait_period: assert property (
        surge_clear[0] && !period_done ##1 !period_done[*2] |-> !surge_valid[0])
        else $error("surge result valid before period completion");

    a_surge_valid_again: assert property (
        !surge_valid[0] && period_done && !clr_set[0] |=> surge_valid[0])
        else $error("surge result not valid after period");

    a_log_start_stop: assert property (
        do_log |=> log_run == $past(arg[0]))
        else $error("logging did not follow control argument");

    a_log_cause_clear: assert property (
        do_log && arg[0] |=> cause == msch_pkg::MSCH_CAUSE_NONE && log_run)
        else $error("end cause not cleared on start");

    a_log_cause_kept: assert property (
        !log_run && !(do_log && arg[0]) |=> $stable(cause))
        else $error("end cause changed while idle");

    a_fault_size_code: assert property (
        log_run && log_fault && log_fault_cause == 3'h1 && !do_log
            |=> !log_run && cause == msch_pkg::MSCH_CAUSE_SIZE)
        else $error("size limit code wrong");

    a_fault_removed_code: assert property (
        log_run && log_fault && log_fault_cause == 3'h4 && !do_log
            |=> cause == msch_pkg::MSCH_CAUSE_REMOVED)
        else $error("drive removed code wrong");

    a_trend_discard: assert property (
        do_trend && arg[0] |=> trend_discard && trend_run ##1 !trend_discard)
        else $error("trend restart did not discard trend_capture_query");

    a_trend_state_bit: assert property (
        do_trend |=> state_word[`MSCH_ST_TREND_BIT] == $past(arg[0]))
        else $error("trend query bit wrong");

    a_freeze_follow: assert property (
        do_freeze |=> freeze == $past(arg[0]) ##1 (freeze || !$past(freeze)))
        else $error("freeze did not follow command");

    a_freeze_state_bit: assert property (
        do_freeze |=> state_word[`MSCH_ST_FREEZE_BIT] == $past(arg[0]))
        else $error("freeze query bit wrong");

    a_bad_arg_no_change: assert property (
        cmd_wr && !sel_bad && op_known && !arg_ok(op, arg)
            |=> $stable(freeze) && $stable(trend_run)
            && ($stable(log_run) || $past(log_end_evt)) && err == msch_pkg::MSCH_ERR_ARG)
        else $error("out of range argument changed state");

    c_log_fault_end: cover property (log_run ##[1:20] log_end_evt);
    c_surge_cycle: cover property (do_clr ##[1:30] (|surge_ok_evt));
    c_bad_arg: cover property (cmd_wr && next_err == msch_pkg::MSCH_ERR_ARG);
    c_irq_raised: cover property (!irq ##1 irq);
endmodule

// ---- testbench/msch_engine_model.sv ----
// behavioural measurement engine and logging storage beside the command handler
`timescale 1ns/1ps
module msch_engine_model (
    // clock
    input wire logic clk_sys,
    // towards the handler
    output logic period_done,
    output logic log_fault,
    output logic [2:0] log_fault_cause
);
    initial begin
        period_done = 1'b0;
        log_fault = 1'b0;
        log_fault_cause = 3'h5;
    end

    // ----------------------------------------
    // one-cycle events
    // ----------------------------------------
    task automatic period();
        @(posedge clk_sys);
        period_done <= 1'b1;
        @(posedge clk_sys);
        period_done <= 1'b0;
    endtask

    // the cause code is only qualified by log_fault, so it is scrambled outside the pulse
    task automatic fault(input logic [2:0] c);
        @(posedge clk_sys);
        log_fault <= 1'b1;
        log_fault_cause <= c;
        @(posedge clk_sys);
        log_fault <= 1'b0;
        log_fault_cause <= ~c;
    endtask
endmodule

// ---- testbench/measurement_state_command_handler_test.sv ----
// self-checking bench of the command handler over apb
`timescale 1ns/1ps
`include "msch_regs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
    $display("Error at %0t: got %h exp %h", $time, (a), (b)); end end
module measurement_state_command_handler_test;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic period_done;
    logic log_fault;
    logic [2:0] log_fault_cause;
    logic [2:0] surge_clear;
    logic [2:0] surge_valid;
    logic freeze;
    logic log_run;
    logic trend_run;
    logic trend_discard;
    logic irq;
    logic [31:0] rq;
    logic re;
    logic [2:0] sc_or = 3'h0;
    int n_disc = 0;
    int miscompares = 0;
    int n_checks = 0;
    logic [2:0] cin [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
    logic [2:0] cexp [4] = '{3'h1, 3'h2, 3'h4, 3'h3};

    msch_top #(.NUM_ANALYZERS(3)) dut (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .period_done(period_done),
        .surge_clear(surge_clear), .surge_valid(surge_valid), .freeze(freeze),
        .log_fault(log_fault), .log_fault_cause(log_fault_cause), .log_run(log_run),
        .trend_run(trend_run), .trend_discard(trend_discard), .irq(irq));
    msch_engine_model eng (.clk_sys(clk_sys), .period_done(period_done),
        .log_fault(log_fault), .log_fault_cause(log_fault_cause));

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    // pulses are counted at the falling edge, where they have settled, so a scenario
    // may zero a counter at a rising edge without racing the count
    always @(negedge clk_sys) begin
        if (trend_discard === 1'b1) n_disc++;
        sc_or = sc_or | surge_clear;
    end

    // ----------------------------------------
    // apb master
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle cycle, so the next setup never reassigns psel in this step
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        `CHK(pready, 1'b1)
        rd(`MSCH_STATE_OFF);
        `CHK(rq, 32'h0000_0000)
        rd(`MSCH_AVAIL_OFF);
        `CHK(rq, 32'h0000_0001)
        rd(`MSCH_ERR_OFF);
        `CHK(rq, 32'h0000_0000)
    endtask

    task automatic t_log();
        wr(`MSCH_CMD_OFF, 32'h0000_0012);
        rd(`MSCH_STATE_OFF);
        `CHK(rq, 32'h0000_0001)
        for (int i = 0; i < 4; i++) begin
            eng.fault(cin[i]);
            @(posedge clk_sys);
            `CHK(log_run, 1'b0)
            rd(`MSCH_STATE_OFF);
            `CHK(rq, {25'h0, cexp[i], 4'h0})
            wr(`MSCH_CMD_OFF, 32'h0000_0012);
            rd(`MSCH_STATE_OFF);
            `CHK(rq, 32'h0000_0001)
        end
        wr(`MSCH_CMD_OFF, 32'h0000_0002);
        `CHK(log_run, 1'b0)
        rd(`MSCH_IRQ_STAT_OFF);
        `CHK(rq, 32'h0000_0002)
        wr(`MSCH_IRQ_STAT_OFF, 32'h0000_0007);
    endtask

    task automatic t_trend();
        n_disc = 0;
        wr(`MSCH_CMD_OFF, 32'h0000_0013);
        `CHK(trend_run, 1'b1)
        wr(`MSCH_CMD_OFF, 32'h0000_0013);
        rd(`MSCH_STATE_OFF);
        `CHK(rq, 32'h0000_0100)
        `CHK(n_disc, 2)
        wr(`MSCH_CMD_OFF, 32'h0000_0003);
        rd(`MSCH_STATE_OFF);
        `CHK(rq, 32'h0000_0000)
    endtask

    task automatic t_freeze();
        wr(`MSCH_CMD_OFF, 32'h0000_0014);
        `CHK(freeze, 1'b1)
        rd(`MSCH_STATE_OFF);
        `CHK(rq, 32'h0000_0200)
        wr(`MSCH_CMD_OFF, 32'h0000_0004);
        `CHK(freeze, 1'b0)
    endtask

    task automatic t_err();
        wr(`MSCH_CMD_OFF, 32'h0000_0014);
        wr(`MSCH_CMD_OFF, 32'h0000_0024);
        rd(`MSCH_ERR_OFF);
        `CHK(rq, 32'h0000_0002)
        `CHK(freeze, 1'b1)
        wr(`MSCH_CMD_OFF, 32'h0000_0004);
        sc_or = 3'h0;
        wr(`MSCH_CMD_OFF, 32'h0000_1101);
        rd(`MSCH_ERR_OFF);
        `CHK(rq, 32'h0000_0003)
        `CHK(sc_or, 3'h0)
        wr(`MSCH_CMD_OFF, 32'h0000_1314);
        `CHK(freeze, 1'b0)
        rd(`MSCH_ERR_OFF);
        `CHK(rq, 32'h0000_0003)
        wr(`MSCH_AVAIL_OFF, 32'h0000_0003);
        wr(`MSCH_CMD_OFF, 32'h0000_1101);
        rd(`MSCH_ERR_OFF);
        `CHK(rq, 32'h0000_0000)
        `CHK(sc_or, 3'h2)
        wr(`MSCH_CMD_OFF, 32'h0000_0007);
        rd(`MSCH_ERR_OFF);
        `CHK(rq, 32'h0000_0001)
        `CHK(irq, 1'b0)
        wr(`MSCH_IRQ_MASK_OFF, 32'h0000_0001);
        `CHK(irq, 1'b1)
        wr(`MSCH_IRQ_STAT_OFF, 32'h0000_0001);
        `CHK(irq, 1'b0)
        rd(12'h020);
        `CHK(re, 1'b1)
    endtask

    task automatic t_surge();
        eng.period();
        @(posedge clk_sys);
        `CHK(surge_valid, 3'h7)
        sc_or = 3'h0;
        wr(`MSCH_CMD_OFF, 32'h0000_0001);
        `CHK(sc_or, 3'h7)
        `CHK(surge_valid, 3'h0)
        wr(`MSCH_IRQ_STAT_OFF, 32'h0000_0004);
        rd(`MSCH_IRQ_STAT_OFF);
        `CHK(rq[2], 1'b0)
        eng.period();
        @(posedge clk_sys);
        `CHK(surge_valid, 3'h7)
        rd(`MSCH_IRQ_STAT_OFF);
        `CHK(rq[2], 1'b1)
    endtask

    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
        t_reset();
        t_log();
        t_trend();
        t_freeze();
        t_err();
        t_surge();
        report_and_stop();
    end
endmodule
